// ---- hdl/interprocessor_dma_link_control.sv ----
// Link control for one end of a back-to-back DMA interprocessor channel
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ns

// Overview of operation
// - Move blocks of consecutive words between memories, up to 32K words.
// - Only one direction active; the idle path ignores cycle triggers.
// - Word mode uses program transfers; block mode uses DMA on both buses.
// - Word written to data buffer appears at companion's read data mux.
// - Transmitter holds each fetched word until the receiver's write takes it.
// - Local status 3:1 appear as companion's read-only status 11:9.
// - Setting interrupt request sends one attention pulse of about 500 ns.
// - Incoming attention sets ready and shows briefly on status bit 13.
// - Ready with interrupt enable set raises an interrupt request.
// - Initialize is forwarded; at the far end it sets ready and interrupts.
// - Initialize resets all local registers (ready set, delay to RST_DELAY, rest cleared) and aborts any block transfer.
// - Block cycles pair up: transmitter read, then receiver write, repeated.
// - Direction 0 is transmit, 1 receive; mode 0 is block.
// - Receiver's go alone is carried across as the first-cycle trigger.
// - Transmitter's go with cycle bit starts its own first read at once.
// - After a read, stretched cycle request is sent; trailing edge starts write.
// - After a write, stretched cycle request starts the transmitter's next read.
// - Word counter overflow halts the alternating sequence.
// - Each inter-cycle delay is adjustable, 1 to 8191 clock cycles (8 ns to about 65.5 microseconds).
// - Word counter holds two's complement count, increments, overflow sets ready.
// - While ready, no DMA cycles start; writing go clears ready.
// - Go is a write pulse only and always reads as zero.
module interprocessor_dma_link_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_init,
  output logic intr_req,
  output logic mem_req,
  output logic mem_write,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output link_ctrl_pkg::link_t link_out,
  input wire link_ctrl_pkg::link_t link_in
);

  typedef enum logic [1:0] {S_IDLE, S_READ, S_WRITE, S_STRETCH} dma_state_t;

  dma_state_t state_r;
  dma_state_t state_nxt;
  logic ready_r;
  logic ie_r;
  logic cycle_r;
  logic out_intr_r;
  logic out_direc_r;
  logic out_mode_r;
  logic [15:0] word_count_r;
  logic [14:0] bus_pointer_r;
  logic [15:0] data_buffer_r;
  logic [12:0] delay_tc_r;
  logic [12:0] delay_cnt_r;
  logic [6:0] companion_attention_pulse_cnt_r;
  logic cyc_req_prev_r;
  logic go_pulse_r;
  logic wr_access;
  logic rd_access;
  logic status_wr;
  logic go_wr;
  logic own_start;
  logic far_trigger;
  logic cycle_done;
  logic wc_overflow;

  // Decodes one register offset against the bus address
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  assign wr_access = psel & penable & pready & pwrite;
  assign rd_access = psel & penable & ~pready & ~pwrite;
  assign status_wr = wr_access & hit(paddr, link_ctrl_pkg::OFF_STATUS);
  assign go_wr = status_wr & pwdata[link_ctrl_pkg::ST_GO];
  assign own_start = go_wr & pwdata[link_ctrl_pkg::ST_CYCLE] &
                     ~pwdata[link_ctrl_pkg::ST_OUT_DIREC];
  assign far_trigger = cyc_req_prev_r & ~link_in.cycle_req;
  assign cycle_done = (state_r == S_READ || state_r == S_WRITE) & mem_ack;
  assign wc_overflow = cycle_done & (word_count_r == 16'hffff);

  // APB slave: one wait state, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & penable & ~pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pslverr <= 1'b0;
      if (psel & penable & ~pready) begin
        prdata <= 32'h0000_0000;
        if (hit(paddr, link_ctrl_pkg::OFF_STATUS)) begin
          if (rd_access) begin
            prdata[link_ctrl_pkg::ST_COMPANION_ATTENTION_PULSE] <= link_in.attention;
            prdata[link_ctrl_pkg::ST_IN_INTR] <= link_in.intr_req;
            prdata[link_ctrl_pkg::ST_IN_DIREC] <= link_in.direc;
            prdata[link_ctrl_pkg::ST_IN_MODE] <= link_in.mode;
            prdata[link_ctrl_pkg::ST_CYCLE] <= cycle_r;
            prdata[link_ctrl_pkg::ST_READY] <= ready_r;
            prdata[link_ctrl_pkg::ST_IE] <= ie_r;
            prdata[link_ctrl_pkg::ST_OUT_INTR] <= out_intr_r;
            prdata[link_ctrl_pkg::ST_OUT_DIREC] <= out_direc_r;
            prdata[link_ctrl_pkg::ST_OUT_MODE] <= out_mode_r;
            prdata[link_ctrl_pkg::ST_GO] <= 1'b0;
          end
        end else if (hit(paddr, link_ctrl_pkg::OFF_WORD_COUNT)) begin
          prdata[15:0] <= word_count_r;
        end else if (hit(paddr, link_ctrl_pkg::OFF_BUS_POINTER)) begin
          prdata[15:0] <= {bus_pointer_r, 1'b0};
        end else if (hit(paddr, link_ctrl_pkg::OFF_DATA_BUFFER)) begin
          prdata[15:0] <= link_in.data;
        end else if (hit(paddr, link_ctrl_pkg::OFF_DELAY)) begin
          prdata[12:0] <= delay_tc_r;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Status control bits; local initialize clears everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_r <= 1'b0;
      out_intr_r <= 1'b0;
      out_direc_r <= 1'b0;
      out_mode_r <= 1'b0;
    end else if (clk_en) begin
      if (bus_init) begin
        ie_r <= 1'b0;
        out_intr_r <= 1'b0;
        out_direc_r <= 1'b0;
        out_mode_r <= 1'b0;
      end else if (status_wr) begin
        ie_r <= pwdata[link_ctrl_pkg::ST_IE];
        out_intr_r <= pwdata[link_ctrl_pkg::ST_OUT_INTR];
        out_direc_r <= pwdata[link_ctrl_pkg::ST_OUT_DIREC];
        out_mode_r <= pwdata[link_ctrl_pkg::ST_OUT_MODE];
      end
    end
  end

  // Ready: set events win over the clear by go
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_r <= link_ctrl_pkg::RST_READY;
    end else if (clk_en) begin
      if (bus_init | link_in.attention | link_in.init | wc_overflow) begin
        ready_r <= 1'b1;
      end else if (go_wr) begin
        ready_r <= 1'b0;
      end
    end
  end

  // Cycle bit: set by own start or far trigger, cleared when the cycle begins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_r <= 1'b0;
    end else if (clk_en) begin
      if (bus_init) begin
        cycle_r <= 1'b0;
      end else if (own_start | (far_trigger & ~out_direc_r & ~ready_r)) begin
        cycle_r <= 1'b1;
      end else if (state_r == S_IDLE && state_nxt == S_READ) begin
        cycle_r <= 1'b0;
      end
    end
  end

  // Counter and pointer advance per completed bus cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_count_r <= link_ctrl_pkg::RST_WORD;
      bus_pointer_r <= 15'h0000;
    end else if (clk_en) begin
      if (bus_init) begin
        word_count_r <= link_ctrl_pkg::RST_WORD;
        bus_pointer_r <= 15'h0000;
      end else if (cycle_done) begin
        word_count_r <= word_count_r + 16'h0001;
        bus_pointer_r <= bus_pointer_r + 15'h0001;
      end else if (wr_access) begin
        if (hit(paddr, link_ctrl_pkg::OFF_WORD_COUNT)) begin
          word_count_r <= pwdata[15:0];
        end
        if (hit(paddr, link_ctrl_pkg::OFF_BUS_POINTER)) begin
          bus_pointer_r <= pwdata[15:1];
        end
      end
    end
  end

  // Data buffer: program word or fetched word, held until next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_buffer_r <= link_ctrl_pkg::RST_WORD;
    end else if (clk_en) begin
      if (bus_init) begin
        data_buffer_r <= link_ctrl_pkg::RST_WORD;
      end else if (state_r == S_READ && mem_ack) begin
        data_buffer_r <= mem_rdata;
      end else if (wr_access && hit(paddr, link_ctrl_pkg::OFF_DATA_BUFFER)) begin
        data_buffer_r <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_tc_r <= link_ctrl_pkg::RST_DELAY;
    end else if (clk_en) begin
      if (bus_init) begin
        delay_tc_r <= link_ctrl_pkg::RST_DELAY;
      end else if (wr_access && hit(paddr, link_ctrl_pkg::OFF_DELAY)) begin
        delay_tc_r <= (pwdata[12:0] == 13'h0000) ? 13'h0001 : pwdata[12:0];
      end
    end
  end

  // Block-mode sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (!ready_r && !out_direc_r && (cycle_r || own_start)) begin
          state_nxt = S_READ;
        end else if (!ready_r && out_direc_r && far_trigger) begin
          state_nxt = S_WRITE;
        end
      end
      S_READ: begin
        if (mem_ack) begin
          state_nxt = S_STRETCH;
        end
      end
      S_WRITE: begin
        if (mem_ack) begin
          state_nxt = S_STRETCH;
        end
      end
      S_STRETCH: begin
        if (delay_cnt_r >= delay_tc_r) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      delay_cnt_r <= 13'h0000;
    end else if (clk_en) begin
      if (bus_init) begin
        state_r <= S_IDLE;
        delay_cnt_r <= 13'h0000;
      end else begin
        state_r <= state_nxt;
        delay_cnt_r <= (state_r == S_STRETCH) ? delay_cnt_r + 13'h0001 : 13'h0001;
      end
    end
  end

  // Memory bus master request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
    end else if (clk_en) begin
      mem_req <= ~bus_init & (state_nxt == S_READ || state_nxt == S_WRITE);
      mem_write <= (state_nxt == S_WRITE);
      mem_addr <= {bus_pointer_r, 1'b0};
      mem_wdata <= link_in.data;
    end
  end

  // Attention pulse on rising interrupt request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      companion_attention_pulse_cnt_r <= 7'h00;
    end else if (clk_en) begin
      if (status_wr && pwdata[link_ctrl_pkg::ST_OUT_INTR] && !out_intr_r && !bus_init) begin
        companion_attention_pulse_cnt_r <= 7'(link_ctrl_pkg::COMPANION_ATTENTION_PULSE_CYCLES);
      end else if (companion_attention_pulse_cnt_r != 7'h00) begin
        companion_attention_pulse_cnt_r <= companion_attention_pulse_cnt_r - 7'h01;
      end
    end
  end

  // Receiver go is a one-cycle first-cycle request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_pulse_r <= 1'b0;
      cyc_req_prev_r <= 1'b0;
    end else if (clk_en) begin
      go_pulse_r <= go_wr & ~pwdata[link_ctrl_pkg::ST_CYCLE] &
                    pwdata[link_ctrl_pkg::ST_OUT_DIREC];
      cyc_req_prev_r <= link_in.cycle_req;
    end
  end

  // Cable outputs and interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_out <= '0;
      intr_req <= 1'b0;
    end else if (clk_en) begin
      link_out.intr_req <= out_intr_r;
      link_out.direc <= out_direc_r;
      link_out.mode <= out_mode_r;
      link_out.attention <= (companion_attention_pulse_cnt_r != 7'h00);
      link_out.init <= bus_init;
      link_out.cycle_req <= ~bus_init & (go_pulse_r | (state_r == S_STRETCH));
      link_out.data <= data_buffer_r;
      intr_req <= ie_r & ready_r;
    end
  end

endmodule : interprocessor_dma_link_control

// ---- hdl/link_ctrl_pkg.sv ----
// Package for the interprocessor link control block
package link_ctrl_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_WORD_COUNT = 8'h04;
  localparam logic [7:0] OFF_BUS_POINTER = 8'h08;
  localparam logic [7:0] OFF_DATA_BUFFER = 8'h0c;
  localparam logic [7:0] OFF_DELAY = 8'h10;

  // Status field positions
  localparam int ST_GO = 0;
  localparam int ST_OUT_MODE = 1;
  localparam int ST_OUT_DIREC = 2;
  localparam int ST_OUT_INTR = 3;
  localparam int ST_IE = 6;
  localparam int ST_READY = 7;
  localparam int ST_CYCLE = 8;
  localparam int ST_IN_MODE = 9;
  localparam int ST_IN_DIREC = 10;
  localparam int ST_IN_INTR = 11;
  localparam int ST_COMPANION_ATTENTION_PULSE = 13;

  // Reset values
  localparam logic RST_READY = 1'b1;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int COMPANION_ATTENTION_PULSE_PULSE_NS = 500;
  localparam int DELAY_MIN_NS = 5000;
  localparam int COMPANION_ATTENTION_PULSE_CYCLES = COMPANION_ATTENTION_PULSE_PULSE_NS / CLK_PERIOD_NS;
  localparam int DELAY_MIN_CYCLES = (DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [12:0] RST_DELAY = 13'(DELAY_MIN_CYCLES);

  typedef enum logic [1:0] {
    DIR_TRANSMIT_VAL = 2'h0,
    DIR_RECEIVE_VAL = 2'h1
  } dir_code_t;

  // One direction of the cable
  typedef struct packed {
    logic intr_req;
    logic direc;
    logic mode;
    logic attention;
    logic init;
    logic cycle_req;
    logic [15:0] data;
  } link_t;
endpackage : link_ctrl_pkg

// ---- tb/companion_model.sv ----
// Behavioural companion interface across the link cable
`timescale 1ns/1ns
module companion_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire link_ctrl_pkg::link_t link_out,
  output link_ctrl_pkg::link_t link_in,
  input wire logic [2:0] st,
  input wire logic [15:0] word,
  input wire logic [15:0] ntx,
  input wire logic slow,
  input wire logic fwd_init,
  output logic rx_valid,
  output logic [15:0] rx_word
);
  logic prev_cyc, prev_intr;
  logic [6:0] att, stretch;
  logic [15:0] sent;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_in <= '0;
      {prev_cyc, prev_intr, rx_valid, att, stretch, sent, rx_word} <= '0;
    end else begin
      rx_valid <= 1'b0;
      {link_in.intr_req, link_in.direc, link_in.mode} <= st;
      prev_cyc <= link_out.cycle_req;
      prev_intr <= st[2];
      att <= (st[2] && !prev_intr) ? 7'h3e : att - 7'(att != 7'h00);
      link_in.attention <= att != 7'h00;
      link_in.init <= fwd_init;
      link_in.cycle_req <= stretch != 7'h00;
      if (stretch != 7'h00) stretch <= stretch - 7'h01;
      // Trailing edge of the far trigger starts our cycle
      if (prev_cyc && !link_out.cycle_req) begin
        if (st[1]) begin
          rx_valid <= 1'b1;
          rx_word <= link_out.data;
          stretch <= slow ? 7'h28 : 7'h04;
        end else if (sent < ntx) begin
          link_in.data <= word + sent;
          sent <= sent + 16'h0001;
          stretch <= slow ? 7'h28 : 7'h04;
        end
      end
      if (ntx == 16'h0000) begin
        sent <= 16'h0000;
        link_in.data <= word;
      end
    end
  end
endmodule : companion_model

// ---- tb/link_ctrl_asserts.sv ----
// Port checks for the link control block
`timescale 1ns/1ns
module link_ctrl_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic bus_init,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire link_ctrl_pkg::link_t link_out
);
  logic wr;
  assign wr = psel && penable && pready && pwrite && !bus_init;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing");
  AST_STATUS_OUT: assert property (wr && paddr == link_ctrl_pkg::OFF_STATUS |-> ##2
    {link_out.intr_req, link_out.direc, link_out.mode} == $past(pwdata[3:1], 2))
    else $error("status bits not sent");
  AST_DATA_OUT: assert property (wr && paddr == link_ctrl_pkg::OFF_DATA_BUFFER |-> ##2
    link_out.data == $past(pwdata[15:0], 2)) else $error("data word not sent");
  AST_COMPANION_ATTENTION_PULSE: assert property ($rose(link_out.attention) |->
    ##61 link_out.attention ##1 !link_out.attention) else $error("attention width");
  AST_INIT_FWD: assert property (bus_init |=> link_out.init)
    else $error("init not forwarded");
  AST_INIT_CLR: assert property (bus_init |=> !mem_req && !link_out.cycle_req)
    else $error("init did not clear");
  AST_MEM_HOLD: assert property (mem_req && !mem_ack && !bus_init |=>
    mem_req && $stable(mem_addr) && $stable(mem_write)) else $error("mem request moved");
  AST_DIREC: assert property (mem_req |-> mem_write == link_out.direc)
    else $error("cycle kind against direction");
  AST_RD_LOAD: assert property (mem_req && mem_ack && !mem_write |-> ##2
    link_out.data == $past(mem_rdata, 2) ##[0:2] link_out.cycle_req)
    else $error("read word not passed on");
  C_RD: cover property (mem_req && mem_ack && !mem_write);
  C_WR: cover property (mem_req && mem_ack && mem_write);
  C_COMPANION_ATTENTION_PULSE: cover property ($rose(link_out.attention));
endmodule : link_ctrl_asserts
bind interprocessor_dma_link_control link_ctrl_asserts u_link_ctrl_asserts (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .bus_init, .mem_req, .mem_write,
  .mem_addr, .mem_ack, .mem_rdata, .link_out);

// ---- tb/testbench.sv ----
// Self-checking bench for the link control block
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, bus_init = 1'b0, intr_req, mem_req, mem_write, mem_ack = 1'b0;
  logic slow = 1'b0, rx_valid, done = 1'b0, fwd_init = 1'b0;
  logic [15:0] mem_addr, mem_wdata, mem_rdata = 16'h0, word = 16'h0, ntx = 16'h0;
  logic [15:0] key = 16'h0, rx_word, nrd = 16'h0;
  logic [2:0] st = 3'h0, lat = 3'h0;
  link_ctrl_pkg::link_t link_out, link_in;
  int errors = 0, total_checks = 0;
  logic [32:0] rq[$];
  logic [15:0] wq[$];
  logic [31:0] mq[$];
  always #4 pclk = ~pclk;
  interprocessor_dma_link_control u_interprocessor_dma_link_control (.pclk, .presetn,
    .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .bus_init, .intr_req, .mem_req, .mem_write, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
    .link_out, .link_in);
  companion_model u_companion_model (.pclk, .presetn, .link_out, .link_in, .st, .word, .ntx,
    .slow, .fwd_init, .rx_valid, .rx_word);
  // Memory with random latency; data line scrambles between answers
  always @(posedge pclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!mem_req) done <= 1'b0;
    else if (!done && lat != 3'h0) lat <= lat - 3'h1;
    else if (!done) begin
      mem_ack <= 1'b1;
      done <= 1'b1;
      lat <= 3'($urandom % 4);
      mem_rdata <= mem_addr ^ key;
    end
  end
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) `CHK({pslverr, prdata}, rq.pop_front())
    if (mem_ack && mem_write) `CHK({mem_addr, mem_wdata}, mq.pop_front())
    if (mem_ack && !mem_write) nrd <= nrd + 16'h1;
    if (rx_valid) `CHK(rx_word, wq.pop_front())
  end
  task automatic finish_test();
    `CHK(wq.size() + mq.size(), 0)
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic blk(input logic [15:0] n, input logic [15:0] ba, input logic [31:0] s);
    int k;
    k = 0;
    apb(1'b1, link_ctrl_pkg::OFF_DELAY, 32'h3);
    apb(1'b1, link_ctrl_pkg::OFF_WORD_COUNT, {16'h0, -n});
    apb(1'b1, link_ctrl_pkg::OFF_BUS_POINTER, {16'h0, ba});
    nrd <= 16'h0;
    apb(1'b1, link_ctrl_pkg::OFF_STATUS, s);
    repeat (3) @(posedge pclk);
    while (intr_req !== 1'b1 && k < 20000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 20000) begin
      errors++;
      finish_test();
    end
    repeat (20) @(posedge pclk);
    rd(link_ctrl_pkg::OFF_WORD_COUNT, 33'h0);
  endtask : blk
  initial begin
    logic [15:0] n;
    void'($urandom(32'h6e57));
    key = 16'($urandom);
    word = 16'($urandom);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(link_ctrl_pkg::OFF_STATUS, 33'h80);
    rd(link_ctrl_pkg::OFF_WORD_COUNT, 33'h0);
    rd(link_ctrl_pkg::OFF_BUS_POINTER, 33'h0);
    rd(link_ctrl_pkg::OFF_DELAY, {20'h0, link_ctrl_pkg::RST_DELAY});
    rd(8'h14, 33'h1_0000_0000);
    apb(1'b1, link_ctrl_pkg::OFF_STATUS, 32'h4f);
    repeat (3) @(posedge pclk);
    `CHK(intr_req, 1'b0)
    rd(link_ctrl_pkg::OFF_STATUS, 33'h4e);
    fwd_init <= 1'b1;
    @(posedge pclk);
    fwd_init <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK(intr_req, 1'b1)
    apb(1'b1, link_ctrl_pkg::OFF_STATUS, 32'h4f);
    repeat (3) @(posedge pclk);
    `CHK(intr_req, 1'b0)
    st <= 3'h5;
    repeat (70) @(posedge pclk);
    `CHK(intr_req, 1'b1)
    rd(link_ctrl_pkg::OFF_STATUS, 33'hace);
    apb(1'b1, link_ctrl_pkg::OFF_DATA_BUFFER, 32'hffff_1234);
    rd(link_ctrl_pkg::OFF_DATA_BUFFER, {17'h0, word});
    st <= 3'h0;
    @(posedge pclk);
    bus_init <= 1'b1;
    @(posedge pclk);
    bus_init <= 1'b0;
    rd(link_ctrl_pkg::OFF_STATUS, 33'h80);
    n = 16'(2 + $urandom % 4);
    st <= 3'h2;
    for (int i = 0; i < n; i++) wq.push_back(16'(16'h0100 + 2 * i) ^ key);
    blk(n, 16'h0100, 32'h141);
    `CHK(nrd, n)
    n = 16'(1 + $urandom % 4);
    slow <= 1'b1;
    st <= 3'h0;
    ntx <= n;
    for (int i = 0; i < n; i++) mq.push_back({16'(16'h0200 + 2 * i), 16'(word + i)});
    blk(n, 16'h0200, 32'h45);
    finish_test();
  end
endmodule : testbench
